// *** core/dcw_pkg.sv ***
/*
  Package for the device configuration word bank: register byte offsets,
  field positions, reset values and decode tables.
  Assumes an AXI4-Lite master with 32-bit data on the core side.
*/
package dcw_pkg;
  // register byte offsets
  localparam logic [11:0] OFF_PLL_CFG  = 12'h000;
  localparam logic [11:0] OFF_USB_CFG  = 12'h004;
  localparam logic [11:0] OFF_CTRL     = 12'h008;
  localparam logic [11:0] OFF_UNLOCK   = 12'h00C;
  localparam logic [31:0] UNLOCK_KEY1  = 32'hAA99_6655;
  localparam logic [31:0] UNLOCK_KEY2  = 32'h5566_99AA;
  // pll word fields
  localparam int ODIV_LO = 16;
  localparam int UBYP_BIT = 15;
  localparam int UIDIV_LO = 8;
  localparam int MUL_LO = 4;
  localparam int IDIV_LO = 0;
  localparam logic [31:0] PLL_RSVD_MASK = 32'hFFF8_7888;
  // usb word fields
  localparam int VBUS_OWN_BIT = 31;
  localparam int ID_OWN_BIT   = 30;
  localparam int REMAP_1WAY_BIT  = 29;
  localparam int MODOFF_1WAY_BIT = 28;
  localparam logic [31:0] USB_RSVD_MASK = 32'h0FFF_0000;
  // control register fields
  localparam int REMAP_LOCK_BIT  = 13;
  localparam int MODOFF_LOCK_BIT = 12;
  localparam int JTAG_EN_BIT  = 3;
  localparam int FIXED1_BIT   = 1;
  localparam int TDO_USE_BIT  = 0;
  localparam logic JTAG_EN_RST = 1'b1;
  localparam logic TDO_USE_RST = 1'b1;
  // axi responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // output divisor as a power of two
  function automatic logic [3:0] odivLog2(input logic [2:0] c);
    case (c)
      3'h7: odivLog2 = 4'h8;
      3'h6: odivLog2 = 4'h6;
      default: odivLog2 = {1'b0, c};
    endcase
  endfunction
  // input divider ratio (main and usb share the table)
  function automatic logic [3:0] idivRatio(input logic [2:0] c);
    case (c)
      3'h7: idivRatio = 4'hC;
      3'h6: idivRatio = 4'hA;
      3'h5: idivRatio = 4'h6;
      3'h4: idivRatio = 4'h5;
      3'h3: idivRatio = 4'h4;
      3'h2: idivRatio = 4'h3;
      3'h1: idivRatio = 4'h2;
      default: idivRatio = 4'h1;
    endcase
  endfunction
  function automatic logic [4:0] mulFactor(input logic [2:0] c);
    case (c)
      3'h7: mulFactor = 5'd24;
      3'h6: mulFactor = 5'd21;
      3'h5: mulFactor = 5'd20;
      3'h4: mulFactor = 5'd19;
      3'h3: mulFactor = 5'd18;
      3'h2: mulFactor = 5'd17;
      3'h1: mulFactor = 5'd16;
      default: mulFactor = 5'd15;
    endcase
  endfunction
endpackage

// *** core/dcw_config_bank.sv ***
/*
  Configuration word bank: two read-only words sampled at reset and a
  control register with lock bits and test port enables, on AXI4-Lite.
  Assumes config word pins are steady around reset release.
*/
// The register addresses and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
module dcw_config_bank #(
  parameter logic HAS_USB = 1'b1
) (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rstn,
  // configuration word pins
  input  wire logic [31:0] pllWordIn,
  input  wire logic [31:0] usbWordIn,
  // axi4-lite write
  input  wire logic [11:0] awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  // axi4-lite read
  input  wire logic [11:0] araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // clock setup outputs
  output logic [3:0]       pllOutDivLog2,
  output logic [4:0]       pllMulFactor,
  output logic [3:0]       pllInDivRatio,
  output logic             usbPllBypass,
  output logic [3:0]       usbPllInDivRatio,
  // pin ownership and policy outputs
  output logic             busPowerPinUsb,
  output logic             usbIdentPinUsb,
  output logic [15:0]      userIdentifier,
  output logic             pinRemapWriteOk,
  output logic             moduleOffWriteOk,
  output logic             testPortEnable,
  output logic             twoWireTdoUse
);

  typedef enum logic [2:0] {
    DCW_RESET = 3'b001,
    DCW_CAPT  = 3'b010,
    DCW_RUN   = 3'b100
  } dcw_phase_e;

  typedef struct packed {
    dcw_phase_e  phase;
    logic [31:0] pllWord;
    logic [31:0] usbWord;
    logic        remapLock;
    logic        modOffLock;
    logic        remapUsed;
    logic        modOffUsed;
    logic        test_port_enable;
    logic        tdoUse;
    logic [1:0]  unlockStep;
    logic        awHave;
    logic [11:0] awAddr;
    logic        wHave;
    logic [31:0] wData;
    logic [3:0]  wStrb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic [3:0]  odiv;
    logic [4:0]  mul;
    logic [3:0]  idiv;
    logic        ubyp;
    logic [3:0]  uidiv;
    logic        awRdy;
    logic        wRdy;
    logic        arRdy;
    logic        remapOk;
    logic        modOffOk;
  } dcw_state_s;

  dcw_state_s st;
  dcw_state_s next_st;

  function automatic logic [31:0] ctrlView(input dcw_state_s s);
    logic [31:0] v;
    v = 32'h0000_0000;
    v[dcw_pkg::REMAP_LOCK_BIT]  = s.remapLock;
    v[dcw_pkg::MODOFF_LOCK_BIT] = s.modOffLock;
    v[dcw_pkg::JTAG_EN_BIT]  = s.test_port_enable;
    v[dcw_pkg::FIXED1_BIT]   = 1'b1;
    v[dcw_pkg::TDO_USE_BIT]  = s.tdoUse;
    return v;
  endfunction

  logic doWrite;
  logic unlocked;
  logic lowByte;
  logic highByte;
  logic [31:0] wd;

  always_comb begin
    next_st = st;
    wd = st.wData;
    lowByte = st.wStrb[0];
    highByte = st.wStrb[1];
    unlocked = (st.unlockStep == 2'h2);
    doWrite = st.awHave && st.wHave && !st.bvalid;
    case (st.phase)
      DCW_RESET: begin
        next_st.phase = DCW_CAPT;
      end
      DCW_CAPT: begin
        // config words taken once after release, then frozen
        next_st.pllWord = pllWordIn;
        next_st.usbWord = usbWordIn;
        next_st.phase = DCW_RUN;
      end
      default: begin
        next_st.phase = DCW_RUN;
      end
    endcase
    // decoded clock settings
    next_st.odiv = dcw_pkg::odivLog2(st.pllWord[dcw_pkg::ODIV_LO +: 3]);
    next_st.mul  = dcw_pkg::mulFactor(st.pllWord[dcw_pkg::MUL_LO +: 3]);
    next_st.idiv = dcw_pkg::idivRatio(st.pllWord[dcw_pkg::IDIV_LO +: 3]);
    // non-usb variant: bypassed, divider neutral
    next_st.ubyp  = HAS_USB ? st.pllWord[dcw_pkg::UBYP_BIT] : 1'b1;
    next_st.uidiv = HAS_USB ? dcw_pkg::idivRatio(st.pllWord[dcw_pkg::UIDIV_LO +: 3])
                            : 4'h1;
    // axi write capture
    if (awvalid && !st.awHave) begin
      next_st.awHave = 1'b1;
      next_st.awAddr = awaddr;
    end
    if (wvalid && !st.wHave) begin
      next_st.wHave = 1'b1;
      next_st.wData = wdata;
      next_st.wStrb = wstrb;
    end
    if (doWrite) begin
      next_st.awHave = 1'b0;
      next_st.wHave = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = dcw_pkg::RESP_OKAY;
      if (st.awAddr == dcw_pkg::OFF_CTRL) begin
        if (lowByte) begin
          next_st.test_port_enable = wd[dcw_pkg::JTAG_EN_BIT];
          next_st.tdoUse = wd[dcw_pkg::TDO_USE_BIT];
        end
        // lock changes need unlock; one-way policy freezes after first change
        if (highByte && unlocked) begin
          if (!(st.usbWord[dcw_pkg::REMAP_1WAY_BIT] && st.remapUsed) &&
              wd[dcw_pkg::REMAP_LOCK_BIT] != st.remapLock) begin
            next_st.remapLock = wd[dcw_pkg::REMAP_LOCK_BIT];
            next_st.remapUsed = 1'b1;
          end
          if (!(st.usbWord[dcw_pkg::MODOFF_1WAY_BIT] && st.modOffUsed) &&
              wd[dcw_pkg::MODOFF_LOCK_BIT] != st.modOffLock) begin
            next_st.modOffLock = wd[dcw_pkg::MODOFF_LOCK_BIT];
            next_st.modOffUsed = 1'b1;
          end
        end
        next_st.unlockStep = 2'h0;
      end else if (st.awAddr == dcw_pkg::OFF_UNLOCK) begin
        if (wd == dcw_pkg::UNLOCK_KEY1) begin
          next_st.unlockStep = 2'h1;
        end else if (wd == dcw_pkg::UNLOCK_KEY2 && st.unlockStep == 2'h1) begin
          next_st.unlockStep = 2'h2;
        end else begin
          next_st.unlockStep = 2'h0;
        end
      end else if (st.awAddr == dcw_pkg::OFF_PLL_CFG ||
                   st.awAddr == dcw_pkg::OFF_USB_CFG) begin
        next_st.bresp = dcw_pkg::RESP_OKAY; // read-only, write dropped
      end else begin
        next_st.bresp = dcw_pkg::RESP_SLVERR;
      end
    end
    if (st.bvalid && bready) begin
      next_st.bvalid = 1'b0;
    end
    // axi read
    if (st.rvalid && rready) begin
      next_st.rvalid = 1'b0;
    end
    if (arvalid && !st.rvalid) begin
      next_st.rvalid = 1'b1;
      next_st.rresp = dcw_pkg::RESP_OKAY;
      if (araddr == dcw_pkg::OFF_PLL_CFG) begin
        next_st.rdata = st.pllWord;
      end else if (araddr == dcw_pkg::OFF_USB_CFG) begin
        next_st.rdata = st.usbWord;
      end else if (araddr == dcw_pkg::OFF_CTRL) begin
        next_st.rdata = ctrlView(st);
      end else if (araddr == dcw_pkg::OFF_UNLOCK) begin
        next_st.rdata = {30'h0000_0000, st.unlockStep};
      end else begin
        next_st.rdata = 32'h0000_0000;
        next_st.rresp = dcw_pkg::RESP_SLVERR;
      end
    end
    // ready and permit outputs kept as flops, no gate between state and pin
    next_st.awRdy    = !next_st.awHave;
    next_st.wRdy     = !next_st.wHave;
    next_st.arRdy    = !next_st.rvalid;
    next_st.remapOk  = !next_st.remapLock;
    next_st.modOffOk = !next_st.modOffLock;
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      st <= '{phase: DCW_RESET, pllWord: 32'hFFFF_FFFF, usbWord: 32'hFFFF_FFFF,
              test_port_enable: dcw_pkg::JTAG_EN_RST, tdoUse: dcw_pkg::TDO_USE_RST,
              odiv: 4'h0, mul: 5'd15, idiv: 4'h1, ubyp: 1'b1, uidiv: 4'h1,
              awRdy: 1'b1, wRdy: 1'b1, arRdy: 1'b1, remapOk: 1'b1, modOffOk: 1'b1,
              default: '0};
    end else begin
      st <= next_st;
    end
  end

  // bus ports
  assign awready = st.awRdy;
  assign wready  = st.wRdy;
  assign bvalid  = st.bvalid;
  assign bresp   = st.bresp;
  assign arready = st.arRdy;
  assign rvalid  = st.rvalid;
  assign rdata   = st.rdata;
  assign rresp   = st.rresp;
  // settings ports
  assign pllOutDivLog2    = st.odiv;
  assign pllMulFactor     = st.mul;
  assign pllInDivRatio    = st.idiv;
  assign usbPllBypass     = st.ubyp;
  assign usbPllInDivRatio = st.uidiv;
  assign busPowerPinUsb   = st.usbWord[dcw_pkg::VBUS_OWN_BIT];
  assign usbIdentPinUsb   = st.usbWord[dcw_pkg::ID_OWN_BIT];
  assign userIdentifier   = st.usbWord[15:0];
  assign pinRemapWriteOk  = st.remapOk;
  assign moduleOffWriteOk = st.modOffOk;
  assign testPortEnable   = st.test_port_enable;
  assign twoWireTdoUse    = st.tdoUse;

  a_lock_needs_unlock: assert property (@(posedge mclk) disable iff (!rstn)
    (st.unlockStep != 2'h2) |=> $stable(st.remapLock) && $stable(st.modOffLock))
    else $error("lock bit changed without unlock");
  a_remap_one_way: assert property (@(posedge mclk) disable iff (!rstn)
    (st.remapUsed && st.usbWord[dcw_pkg::REMAP_1WAY_BIT] && st.phase == DCW_RUN)
      |=> $stable(st.remapLock))
    else $error("pin select lock changed twice under one-way policy");
  a_modoff_one_way: assert property (@(posedge mclk) disable iff (!rstn)
    (st.modOffUsed && st.usbWord[dcw_pkg::MODOFF_1WAY_BIT] && st.phase == DCW_RUN)
      |=> $stable(st.modOffLock))
    else $error("module disable lock changed twice under one-way policy");
  a_words_frozen: assert property (@(posedge mclk) disable iff (!rstn)
    (st.phase == DCW_RUN) |=> $stable(st.pllWord) && $stable(st.usbWord))
    else $error("config word changed at run time");
  a_ctrl_fixed_bits: assert property (@(posedge mclk) disable iff (!rstn)
    (rvalid && $rose(rvalid) && $past(araddr) == dcw_pkg::OFF_CTRL)
      |-> (rdata & 32'hFFFF_CFF6) == 32'h0000_0002)
    else $error("control reserved bits read wrong");
  a_odiv_decode: assert property (@(posedge mclk) disable iff (!rstn)
    (st.phase == DCW_RUN && st.pllWord[18:16] == 3'h7) |=> pllOutDivLog2 == 4'h8)
    else $error("output divisor 256 decode wrong");
  a_mul_decode: assert property (@(posedge mclk) disable iff (!rstn)
    (st.phase == DCW_RUN && st.pllWord[6:4] == 3'h0) |=> pllMulFactor == 5'd15)
    else $error("multiplier 15 decode wrong");
  a_usb_bypass: assert property (@(posedge mclk) disable iff (!rstn)
    (st.phase == DCW_RUN) |=> usbPllBypass == (HAS_USB ? $past(st.pllWord[15]) : 1'b1))
    else $error("usb pll bypass wrong");

  // decode end points of the tables, the divisor 64 code and the non-usb outputs
  a_idiv_top: assert property (@(posedge mclk) disable iff (!rstn)
    (st.phase == DCW_RUN && st.pllWord[2:0] == 3'h7) |=> pllInDivRatio == 4'hC)
    else $error("input divider 12 decode wrong");
  a_idiv_unity: assert property (@(posedge mclk) disable iff (!rstn)
    (st.phase == DCW_RUN && st.pllWord[2:0] == 3'h0) |=> pllInDivRatio == 4'h1)
    else $error("input divider 1 decode wrong");
  a_mul_top: assert property (@(posedge mclk) disable iff (!rstn)
    (st.phase == DCW_RUN && st.pllWord[6:4] == 3'h7) |=> pllMulFactor == 5'h18)
    else $error("multiplier 24 decode wrong");
  a_odiv_unity: assert property (@(posedge mclk) disable iff (!rstn)
    (st.phase == DCW_RUN && st.pllWord[18:16] == 3'h0) |=> pllOutDivLog2 == 4'h0)
    else $error("output divisor 1 decode wrong");
  a_odiv_mid: assert property (@(posedge mclk) disable iff (!rstn)
    (st.phase == DCW_RUN && st.pllWord[18:16] == 3'h6) |=> pllOutDivLog2 == 4'h6)
    else $error("output divisor 64 decode wrong");
  a_udiv_top: assert property (@(posedge mclk) disable iff (!rstn)
    (st.phase == DCW_RUN && HAS_USB && st.pllWord[10:8] == 3'h7) |=> usbPllInDivRatio == 4'hC)
    else $error("usb input divider 12 decode wrong");
  a_udiv_no_usb: assert property (@(posedge mclk) disable iff (!rstn)
    (st.phase == DCW_RUN && !HAS_USB) |=> usbPllInDivRatio == 4'h1)
    else $error("usb divider active without usb");
  a_bypass_no_usb: assert property (@(posedge mclk) disable iff (!rstn)
    (st.phase == DCW_RUN && !HAS_USB) |=> usbPllBypass)
    else $error("usb pll not bypassed without usb");
  // permits and reset values
  a_remap_permit: assert property (@(posedge mclk) disable iff (!rstn)
    pinRemapWriteOk != st.remapLock)
    else $error("pin remap permit disagrees with lock");
  a_modoff_permit: assert property (@(posedge mclk) disable iff (!rstn)
    moduleOffWriteOk != st.modOffLock)
    else $error("module off permit disagrees with lock");
  a_lock_reset: assert property (@(posedge mclk) disable iff (!rstn)
    (st.phase == DCW_RESET) |-> !st.remapLock && !st.modOffLock)
    else $error("lock bits not clear after reset");
  a_port_reset: assert property (@(posedge mclk) disable iff (!rstn)
    (st.phase == DCW_RESET) |-> testPortEnable && twoWireTdoUse)
    else $error("test port bits not set after reset");
  // control writes lane by lane, dropped word writes and unmapped reads
  a_jtag_write: assert property (@(posedge mclk) disable iff (!rstn)
    (doWrite && st.awAddr == dcw_pkg::OFF_CTRL && lowByte)
      |=> testPortEnable == $past(wd[dcw_pkg::JTAG_EN_BIT]))
    else $error("test port enable write lost");
  a_tdo_write: assert property (@(posedge mclk) disable iff (!rstn)
    (doWrite && st.awAddr == dcw_pkg::OFF_CTRL && lowByte)
      |=> twoWireTdoUse == $past(wd[dcw_pkg::TDO_USE_BIT]))
    else $error("tdo use write lost");
  a_low_lane_off: assert property (@(posedge mclk) disable iff (!rstn)
    (doWrite && st.awAddr == dcw_pkg::OFF_CTRL && !lowByte)
      |=> $stable(st.test_port_enable) && $stable(st.tdoUse))
    else $error("port bits changed with lane 0 off");
  a_high_lane_off: assert property (@(posedge mclk) disable iff (!rstn)
    (doWrite && st.awAddr == dcw_pkg::OFF_CTRL && !highByte)
      |=> $stable(st.remapLock) && $stable(st.modOffLock))
    else $error("lock bits changed with lane 1 off");
  a_unlock_clear: assert property (@(posedge mclk) disable iff (!rstn)
    (doWrite && st.awAddr == dcw_pkg::OFF_CTRL) |=> st.unlockStep == 2'h0)
    else $error("unlock survived a control write");
  a_word_write_drop: assert property (@(posedge mclk) disable iff (!rstn)
    (doWrite && (st.awAddr == dcw_pkg::OFF_PLL_CFG || st.awAddr == dcw_pkg::OFF_USB_CFG))
      |=> $stable(st.pllWord) && $stable(st.usbWord) && bresp == dcw_pkg::RESP_OKAY)
    else $error("config word write not dropped");
  a_read_unmapped: assert property (@(posedge mclk) disable iff (!rstn)
    ($rose(rvalid) && $past(araddr) > dcw_pkg::OFF_UNLOCK)
      |-> rresp == dcw_pkg::RESP_SLVERR && rdata == 32'h0000_0000)
    else $error("unmapped read not refused");
  // bus answers
  a_ready_flops: assert property (@(posedge mclk) disable iff (!rstn)
    awready == !st.awHave && wready == !st.wHave && arready == !st.rvalid)
    else $error("ready outputs disagree with holding flags");
  a_write_answer: assert property (@(posedge mclk) disable iff (!rstn)
    doWrite |=> bvalid)
    else $error("write not answered");
  a_read_answer: assert property (@(posedge mclk) disable iff (!rstn)
    (arvalid && arready) |=> rvalid)
    else $error("read not answered");

endmodule

// *** sim/dcw_config_bank_tb.sv ***
/*
  Self-checking bench for the configuration word bank.
  Assumes dcw_pkg and dcw_config_bank are compiled first.
*/
`timescale 1ns/1ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin errors++; \
  $display("ERROR %0t: got %h exp %h", $time, (g), (e)); end end
module dcw_config_bank_tb;
  logic        mclk = 1'b0;
  logic        rstn = 1'b0;
  logic [31:0] pllWordIn = 32'hFFFF_FFFF;
  logic [31:0] usbWordIn = 32'hFFFF_FFFF;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0]  wstrb = 4'hF;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata, rd;
  logic [1:0]  rs;
  logic [3:0]  pllOutDivLog2, pllInDivRatio, usbPllInDivRatio;
  logic [4:0]  pllMulFactor;
  logic        usbPllBypass, busPowerPinUsb, usbIdentPinUsb;
  logic        pinRemapWriteOk, moduleOffWriteOk, testPortEnable, twoWireTdoUse;
  logic [15:0] userIdentifier;
  logic        nuBypass;
  logic [3:0]  nuDivRatio;
  int          errors = 0;
  int          comparisons = 0;
  // expected decode tables, indexed by field code
  logic [3:0]  expOdiv [8] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h8};
  logic [4:0]  expMul  [8] = '{5'd15, 5'd16, 5'd17, 5'd18, 5'd19, 5'd20, 5'd21, 5'd24};
  logic [3:0]  expDiv  [8] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'hA, 4'hC};

  always #20 mclk = ~mclk;

  dcw_config_bank i_dut (.mclk(mclk), .rstn(rstn), .pllWordIn(pllWordIn),
    .usbWordIn(usbWordIn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .pllOutDivLog2(pllOutDivLog2), .pllMulFactor(pllMulFactor),
    .pllInDivRatio(pllInDivRatio), .usbPllBypass(usbPllBypass),
    .usbPllInDivRatio(usbPllInDivRatio), .busPowerPinUsb(busPowerPinUsb),
    .usbIdentPinUsb(usbIdentPinUsb), .userIdentifier(userIdentifier),
    .pinRemapWriteOk(pinRemapWriteOk), .moduleOffWriteOk(moduleOffWriteOk),
    .testPortEnable(testPortEnable), .twoWireTdoUse(twoWireTdoUse));

  // second copy without usb: usb pll fields must be inert
  dcw_config_bank #(.HAS_USB(1'b0)) i_dut_nousb (.mclk(mclk), .rstn(rstn),
    .pllWordIn(pllWordIn), .usbWordIn(usbWordIn), .awaddr(awaddr), .awvalid(1'b0),
    .awready(), .wdata(wdata), .wstrb(wstrb), .wvalid(1'b0), .wready(), .bresp(),
    .bvalid(), .bready(1'b0), .araddr(araddr), .arvalid(1'b0), .arready(), .rdata(),
    .rresp(), .rvalid(), .rready(1'b0), .pllOutDivLog2(), .pllMulFactor(),
    .pllInDivRatio(), .usbPllBypass(nuBypass), .usbPllInDivRatio(nuDivRatio),
    .busPowerPinUsb(), .usbIdentPinUsb(), .userIdentifier(), .pinRemapWriteOk(),
    .moduleOffWriteOk(), .testPortEnable(), .twoWireTdoUse());

  task automatic end_of_test();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // handshakes judged at the falling edge, acted on at the next rising edge
  task automatic axiWrite(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    bit awH, wH, got;
    got = 1'b0;
    @(posedge mclk);
    awaddr <= a; awvalid <= 1'b1; wdata <= d; wvalid <= 1'b1; bready <= 1'b1;
    for (int n = 0; n < 50 && !got; n++) begin
      @(negedge mclk);
      awH = awvalid && awready === 1'b1;
      wH = wvalid && wready === 1'b1;
      got = bvalid === 1'b1;
      r = bresp;
      @(posedge mclk);
      if (awH) awvalid <= 1'b0;
      if (wH) wvalid <= 1'b0;
      if (got) bready <= 1'b0;
    end
    if (!got) begin
      errors++;
      end_of_test();
    end
  endtask

  task automatic axiRead(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    bit arH, got;
    got = 1'b0;
    @(posedge mclk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    for (int n = 0; n < 50 && !got; n++) begin
      @(negedge mclk);
      arH = arvalid && arready === 1'b1;
      got = rvalid === 1'b1;
      d = rdata;
      r = rresp;
      @(posedge mclk);
      if (arH) arvalid <= 1'b0;
      if (got) rready <= 1'b0;
    end
    if (!got) begin
      errors++;
      end_of_test();
    end
  endtask

  task automatic unlock();
    axiWrite(dcw_pkg::OFF_UNLOCK, dcw_pkg::UNLOCK_KEY1, rs);
    axiWrite(dcw_pkg::OFF_UNLOCK, dcw_pkg::UNLOCK_KEY2, rs);
  endtask

  // every field code, one reset each: words are only taken at reset
  task automatic scnCodes();
    logic [2:0]  c;
    logic [31:0] pw, uw;
    for (int i = 0; i < 8; i++) begin
      c = 3'(i);
      pw = dcw_pkg::PLL_RSVD_MASK | {13'h0, c, c[0], 4'h0, c, 1'b0, c, 1'b0, c};
      uw = dcw_pkg::USB_RSVD_MASK | {c[1], c[0], 2'b10, 12'h000, 13'h14B8, c};
      @(posedge mclk);
      rstn <= 1'b0; pllWordIn <= pw; usbWordIn <= uw;
      repeat (10) @(posedge mclk);
      rstn <= 1'b1;
      repeat (3) @(posedge mclk);
      @(negedge mclk);
      `CHK(pllOutDivLog2, expOdiv[i])
      `CHK(usbPllBypass, c[0])
      `CHK(usbPllInDivRatio, expDiv[i])
      `CHK({nuBypass, nuDivRatio}, 5'h11)
      `CHK(pllMulFactor, expMul[i])
      `CHK(pllInDivRatio, expDiv[i])
      `CHK({busPowerPinUsb, usbIdentPinUsb}, c[1:0])
      `CHK(userIdentifier, {13'h14B8, c})
      axiRead(dcw_pkg::OFF_PLL_CFG, rd, rs);
      `CHK(rd, pw)
      axiRead(dcw_pkg::OFF_USB_CFG, rd, rs);
      `CHK(rd, uw)
    end
    // a write to a word is answered but leaves it alone
    axiWrite(dcw_pkg::OFF_PLL_CFG, 32'h0000_0000, rs);
    axiRead(dcw_pkg::OFF_PLL_CFG, rd, rs);
    `CHK(rd, pw)
  endtask

  task automatic scnCtrlNoUnlock();
    axiRead(dcw_pkg::OFF_CTRL, rd, rs);
    `CHK(rd, 32'h0000_000B)
    `CHK({pinRemapWriteOk, moduleOffWriteOk, testPortEnable, twoWireTdoUse}, 4'hF)
    axiWrite(dcw_pkg::OFF_CTRL, 32'hFFFF_FFF4, rs);
    axiRead(dcw_pkg::OFF_CTRL, rd, rs);
    `CHK(rd, 32'h0000_0002)
    @(negedge mclk);
    `CHK({pinRemapWriteOk, moduleOffWriteOk, testPortEnable, twoWireTdoUse}, 4'hC)
  endtask

  // words left pin remap one-way, module disable reusable
  task automatic scnLocks();
    unlock();
    axiRead(dcw_pkg::OFF_UNLOCK, rd, rs);
    `CHK(rd, 32'h0000_0002)
    axiWrite(dcw_pkg::OFF_CTRL, 32'h0000_3009, rs);
    `CHK(rs, dcw_pkg::RESP_OKAY)
    axiRead(dcw_pkg::OFF_CTRL, rd, rs);
    `CHK(rd, 32'h0000_300B)
    `CHK({pinRemapWriteOk, moduleOffWriteOk}, 2'b00)
    unlock();
    axiWrite(dcw_pkg::OFF_CTRL, 32'h0000_0009, rs);
    axiRead(dcw_pkg::OFF_CTRL, rd, rs);
    `CHK(rd, 32'h0000_200B)
    `CHK({pinRemapWriteOk, moduleOffWriteOk}, 2'b01)
  endtask

  // strobe lanes: lane 0 gates port enables, lane 1 gates lock bits
  task automatic scnLanes();
    unlock();
    @(posedge mclk);
    wstrb <= 4'h1;
    axiWrite(dcw_pkg::OFF_CTRL, 32'h0000_1000, rs);
    axiRead(dcw_pkg::OFF_CTRL, rd, rs);
    `CHK(rd, 32'h0000_2002)
    unlock();
    @(posedge mclk);
    wstrb <= 4'h2;
    axiWrite(dcw_pkg::OFF_CTRL, 32'h0000_1009, rs);
    axiRead(dcw_pkg::OFF_CTRL, rd, rs);
    `CHK({rs, rd}, {dcw_pkg::RESP_OKAY, 32'h0000_3002})
    `CHK({moduleOffWriteOk, testPortEnable, twoWireTdoUse}, 3'b000)
    @(posedge mclk);
    wstrb <= 4'hF;
  endtask

  task automatic scnUnmapped();
    axiRead(12'h010, rd, rs);
    `CHK({rs, rd}, {dcw_pkg::RESP_SLVERR, 32'h0000_0000})
    axiWrite(12'h010, 32'hFFFF_FFFF, rs);
    `CHK(rs, dcw_pkg::RESP_SLVERR)
  endtask

  initial begin
    scnCodes();
    scnCtrlNoUnlock();
    scnLocks();
    scnLanes();
    scnUnmapped();
    end_of_test();
  end
endmodule
